// ### selh_defs.vh
// Constants for the stop exit and limp-home sequencer
`ifndef SELH_DEFS_VH
`define SELH_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SELH_ADR_CTRL      4'h0
`define SELH_ADR_STAT      4'h4
`define SELH_ADR_SLOW      4'h8

// ****************************************
// Control register fields
// ****************************************
`define SELH_CTRL_LHD      0
`define SELH_CTRL_CME      1
`define SELH_CTRL_FORCED_CLOCK_MONITOR_ENABLE     2
`define SELH_CTRL_DLY      3
`define SELH_CTRL_LIMP_HOME_INTERRUPT_ENABLE     4
`define SELH_CTRL_BUS_CLOCK_FROM_PLL     5
`define SELH_CTRL_MCS      6
`define SELH_CTRL_PSEUDO_STOP_ENABLE     7
`define SELH_CTRL_PLL_POWER_ON    8
`define SELH_CTRL_RST      9'h102

// ****************************************
// Status register fields
// ****************************************
`define SELH_STAT_LIMP_HOME_ACTIVE_FLAG    0
`define SELH_STAT_LIMP_HOME_INTERRUPT_FLAG     1
`define SELH_STAT_STOP     2

// ****************************************
// Timing counts
// ****************************************
`define SELH_CNT_BITS      13
`define SELH_CNT_MID       13'h1000
`define SELH_SLOW_BITS     6
`define SELH_RESET_ALL     8'h00

`endif

// ### selh_divider.v
// Slow-mode divider producing the divided module clock tick
`timescale 1ns/1ps

module selh_divider #(
  parameter W = 6
) (
  input  wire         clk_i,   // System clock
  input  wire         rst_i,   // Synchronous reset
  input  wire [W-1:0] div_i,   // Divide setting, 0 = no division
  input  wire         src_i,   // Source tick from selected oscillator
  output reg          tick_o   // Divided module clock tick
);

  reg [W:0] cnt_q;

  // ****************************************
  // Divider
  // ****************************************
  // Divides by 2*div, so each slow step adds two source ticks per count
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= {(W+1){1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_i) begin
        if (div_i == {W{1'b0}} || cnt_q >= {div_i, 1'b0} - 1'b1) begin
          cnt_q  <= {(W+1){1'b0}};
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

endmodule

// ### selh_osc_model.sv
// Crystal, backup oscillator and clock monitor model for the bench
`timescale 1ns/1ps

module selh_osc_model (
  input  wire  clk_i,       // System clock
  input  wire  ext_on_i,    // Crystal running
  output logic ext_tick_o,  // External clock tick
  output logic bkp_tick_o,  // Backup oscillator tick
  output logic mon_ok_o     // Monitor sees external clock
);
  logic [3:0] seen_q;       // Settling history of the crystal

  initial begin
    ext_tick_o = 1'b0;
    bkp_tick_o = 1'b0;
    mon_ok_o   = 1'b0;
    seen_q     = 4'h0;
  end

  // Ticks every second cycle; a dead crystal stands still, no stray edges
  always @(posedge clk_i) begin
    bkp_tick_o <= ~bkp_tick_o;
    ext_tick_o <= ext_on_i & ~ext_tick_o;
    seen_q     <= {seen_q[2:0], ext_on_i};
    mon_ok_o   <= &seen_q;  // Slow answer: only a settled clock counts
  end
endmodule

// ### selh_sequencer.v
// Stop exit and limp-home sequencer with Wishbone registers
//
// Overview of operation
// - Without PLL supply, no limp-home; run only on external clock.
// - Delay bit set inserts 4096-count wait; clear inserts none.
// - Wake counter runs on clock after the slow-mode divider.
// - Stop ends on reset, interrupt pins, key or CAN wake-up.
// - No limp-home, monitor off: stop exits on external clock.
// - No limp-home, monitor on: stop acts as monitor failure.
// - Limp-home on: stop masks monitor; exit enters limp-home.
// - Delayed limp exit counts backup clock, leaves if clock seen.
// - No clock after first count: exit stop, stay limp, flag.
// - In limp-home sample monitor every 8192 counts at mid-count.
// - Clock found: leave limp-home, clear status, set interrupt flag.
// - Fast recovery with limp-home: exit stop at once in limp-home.
// - Leaving limp-home restores bus and module clock selects.
// - Square-wave clock, delay clear: no delay, status never set.
// - Pseudo-stop keeps oscillator running, same wake and delay.
// - Delayed pseudo-stop exit enters limp-home, selects forced.
// - After pseudo-stop count resume external if seen, else flag.
// - Status flag set in limp-home; each change sets interrupt flag.
// - In limp-home monitor forced on, module clocks on backup.
// - With PLL supply, reset sets monitor, PLL-on; clears disable.
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "selh_defs.vh"

module selh_sequencer #(
  parameter CNT_W  = `SELH_CNT_BITS,
  parameter SLOW_W = `SELH_SLOW_BITS
) (
  input  wire        clk_i,        // System clock, 50 MHz
  input  wire        rst_i,        // Synchronous reset, active high
  input  wire [3:0]  wb_adr_i,     // Wishbone byte address
  input  wire [31:0] wb_dat_i,     // Wishbone write data
  input  wire [3:0]  wb_sel_i,     // Wishbone byte enables
  input  wire        wb_we_i,      // Wishbone write enable
  input  wire        wb_cyc_i,     // Wishbone cycle
  input  wire        wb_stb_i,     // Wishbone strobe
  output reg  [31:0] wb_dat_o,     // Wishbone read data
  output reg         wb_ack_o,     // Wishbone acknowledge
  input  wire        pll_supply_i, // PLL supply present (pin)
  input  wire        ext_tick_i,   // External clock tick (pin)
  input  wire        bkp_tick_i,   // Backup oscillator tick (pin)
  input  wire        mon_ok_i,     // Clock monitor sees clock (pin)
  input  wire        stop_req_i,   // Stop instruction executed
  input  wire        ext_rst_n_i,  // External reset pin, active low
  input  wire        irq_n_i,      // Maskable interrupt pin, low
  input  wire        nmi_n_i,      // Nonmaskable interrupt pin, low
  input  wire        kwu_j_i,      // Key wake-up from port J
  input  wire        kwu_h_i,      // Key wake-up from port H
  input  wire        can_wu_i,     // CAN controller wake-up
  output reg         stopped_o,    // Core held in stop
  output reg         osc_run_o,    // External oscillator kept running
  output reg         limp_o,       // Limp-home active
  output reg         mon_en_o,     // Effective clock monitor enable
  output reg         bus_pll_o,    // Effective bus clock from PLL
  output reg         mod_sel_o,    // Effective module clock select
  output reg         pll_on_o,     // Effective PLL power on
  output reg         mod_bkp_o,    // Module clocks on backup clock
  output reg         cm_rst_o,     // Clock monitor reset pulse
  output reg         lh_irq_o      // Limp-home interrupt request
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_STOP = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // ****************************************
  // Declarations
  // ****************************************
  reg [8:0]        ctrl_q;
  reg [SLOW_W-1:0] slow_q;
  reg              limp_home_active_flag_q, limp_home_active_flag_d;
  reg              limp_home_interrupt_flag_q;
  reg [1:0]        st_q, st_d;
  reg [CNT_W-1:0]  cnt_q, cnt_d;
  reg              stop_dly_q;   // Delay bit captured at stop entry
  reg              pstop_q;      // Current stop is pseudo-stop
  reg [6:0]        s1_q, s2_q;   // Pin synchronisers
  wire             sup_s, ext_s, bkp_s, mon_s, rstp_s, irq_s, nmi_s;
  wire             src_tick, xtick, wake, mid;
  wire             wb_req, wr_ctrl, wr_stat, wr_slow;

  wire lhd  = ctrl_q[`SELH_CTRL_LHD] | ~sup_s;
  wire clock_monitor_enable  = ctrl_q[`SELH_CTRL_CME];
  wire forced_clock_monitor_enable = ctrl_q[`SELH_CTRL_FORCED_CLOCK_MONITOR_ENABLE];
  wire dly  = ctrl_q[`SELH_CTRL_DLY];
  wire limp_home_interrupt_enable = ctrl_q[`SELH_CTRL_LIMP_HOME_INTERRUPT_ENABLE];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops on each pin input before any logic looks at it; key and CAN wake-ups reach the wake logic directly
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 7'h70;
      s2_q <= 7'h70;
    end else begin
      s1_q <= {nmi_n_i, irq_n_i, ext_rst_n_i, mon_ok_i, bkp_tick_i,
               ext_tick_i, pll_supply_i};
      s2_q <= s1_q;
    end
  end
  assign sup_s  = s2_q[0];
  assign ext_s  = s2_q[1];
  assign bkp_s  = s2_q[2];
  assign mon_s  = s2_q[3];
  assign rstp_s = ~s2_q[4];
  assign irq_s  = ~s2_q[5];
  assign nmi_s  = ~s2_q[6];

  // Any wake source ends stop or pseudo-stop
  assign wake = rstp_s | irq_s | nmi_s | kwu_j_i | kwu_h_i
              | can_wu_i;

  // ****************************************
  // Wake-up counter clock
  // ****************************************
  // Backup oscillator feeds the counter in limp-home, else external
  assign src_tick = limp_home_active_flag_q ? bkp_s : ext_s;

  selh_divider #(
    .W (SLOW_W)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_i  (slow_q),
    .src_i  (src_tick),
    .tick_o (xtick)
  );

  // Mid-count of the 13-stage counter, reached once per wrap
  assign mid = xtick && (cnt_q == `SELH_CNT_MID - 1'b1);

  // ****************************************
  // Sequencer next state
  // ****************************************
  always @* begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    limp_home_active_flag_d = limp_home_active_flag_q;
    if (xtick)
      cnt_d = cnt_q + 1'b1; // Free running in limp-home
    case (st_q)
      ST_RUN: begin
        // Limp-home polling at each mid-count
        if (limp_home_active_flag_q && mid && mon_s)
          limp_home_active_flag_d = 1'b0;
        if (stop_req_i && !(lhd && (clock_monitor_enable || forced_clock_monitor_enable))) begin
          st_d  = ST_STOP;
          cnt_d = {CNT_W{1'b0}};
        end
      end
      ST_STOP: begin
        cnt_d = {CNT_W{1'b0}};
        if (wake) begin
          if (!lhd && (stop_dly_q || !pstop_q))
            limp_home_active_flag_d = 1'b1;
          if (!lhd && !stop_dly_q && !pstop_q && ext_s)
            limp_home_active_flag_d = 1'b0; // Clean square wave, never limp
          if (stop_dly_q)
            st_d = ST_WAIT;
          else
            st_d = ST_RUN;  // No delay
        end
      end
      ST_WAIT: begin
        if (mid) begin
          st_d = ST_RUN; // 4096-count wait done
          if (limp_home_active_flag_q && mon_s)
            limp_home_active_flag_d = 1'b0;
          // Otherwise stay in limp-home with flags set
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  // Reset starts in the wait state with limp-home clear, so the first 4096 counts
  // form the internal reset period on the external clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q       <= ST_WAIT;
      cnt_q      <= {CNT_W{1'b0}};
      limp_home_active_flag_q    <= 1'b0;
      stop_dly_q <= 1'b1;
      pstop_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      limp_home_active_flag_q <= limp_home_active_flag_d & ~lhd;
      if (st_q == ST_RUN && st_d == ST_STOP) begin
        stop_dly_q <= dly;
        pstop_q    <= ctrl_q[`SELH_CTRL_PSEUDO_STOP_ENABLE];
      end
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  // Any flag change sets it; a set in the same cycle beats the clear
  always @(posedge clk_i) begin
    if (rst_i)
      limp_home_interrupt_flag_q <= 1'b0;
    else if (limp_home_active_flag_q != (limp_home_active_flag_d & ~lhd))
      limp_home_interrupt_flag_q <= 1'b1;
    else if (wr_stat && wb_sel_i[0] && wb_dat_i[`SELH_STAT_LIMP_HOME_INTERRUPT_FLAG])
      limp_home_interrupt_flag_q <= 1'b0; // Write one to clear
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == `SELH_ADR_CTRL);
  assign wr_stat = wb_req & wb_we_i & (wb_adr_i == `SELH_ADR_STAT);
  assign wr_slow = wb_req & wb_we_i & (wb_adr_i == `SELH_ADR_SLOW);

  // One wait-free answer per request; unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SELH_ADR_CTRL: wb_dat_o <= {23'h0, ctrl_q};
          `SELH_ADR_STAT: wb_dat_o <= {29'h0, st_q != ST_RUN,
                                       limp_home_interrupt_flag_q, limp_home_active_flag_q};
          `SELH_ADR_SLOW: wb_dat_o <= {{(32-SLOW_W){1'b0}}, slow_q};
          default:        wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Control and slow registers; reset sets monitor and PLL-on
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `SELH_CTRL_RST;
      slow_q <= {SLOW_W{1'b0}};
    end else begin
      if (wr_ctrl && wb_sel_i[0])
        ctrl_q[7:0] <= wb_dat_i[7:0];
      if (wr_ctrl && wb_sel_i[1])
        ctrl_q[8] <= wb_dat_i[8];
      if (wr_slow && wb_sel_i[0])
        slow_q <= wb_dat_i[SLOW_W-1:0];
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Software selects are kept untouched in limp-home, so leaving it
  // restores them automatically
  always @(posedge clk_i) begin
    if (rst_i) begin
      stopped_o <= 1'b1;
      osc_run_o <= 1'b1;
      limp_o    <= 1'b0;
      mon_en_o  <= 1'b0;
      bus_pll_o <= 1'b0;
      mod_sel_o <= 1'b0;
      pll_on_o  <= 1'b0;
      mod_bkp_o <= 1'b0;
      cm_rst_o  <= 1'b0;
      lh_irq_o  <= 1'b0;
    end else begin
      stopped_o <= (st_q != ST_RUN);
      osc_run_o <= (st_q != ST_STOP) | pstop_q;
      limp_o    <= limp_home_active_flag_q;
      mon_en_o  <= limp_home_active_flag_q | ((clock_monitor_enable | forced_clock_monitor_enable) & (st_q == ST_RUN));
      bus_pll_o <= limp_home_active_flag_q | ctrl_q[`SELH_CTRL_BUS_CLOCK_FROM_PLL];
      mod_sel_o <= ~limp_home_active_flag_q & ctrl_q[`SELH_CTRL_MCS];
      pll_on_o  <= sup_s & (limp_home_active_flag_q | ctrl_q[`SELH_CTRL_PLL_POWER_ON]);
      mod_bkp_o <= limp_home_active_flag_q;
      cm_rst_o  <= (st_q == ST_RUN) & stop_req_i & lhd
                 & (clock_monitor_enable | forced_clock_monitor_enable);
      lh_irq_o  <= limp_home_interrupt_flag_q & limp_home_interrupt_enable;
    end
  end

endmodule

// ### selh_sequencer_assertions.sv
// Port-level checks for the stop exit and limp-home sequencer
`timescale 1ns/1ps

module selh_sequencer_assertions (
  input wire clk_i,        // System clock
  input wire rst_i,        // Synchronous reset
  input wire wb_cyc_i,     // Bus cycle
  input wire wb_stb_i,     // Bus strobe
  input wire wb_ack_o,     // Bus acknowledge
  input wire pll_supply_i, // PLL supply present
  input wire stop_req_i,   // Stop instruction
  input wire stopped_o,    // Core held in stop
  input wire limp_o,       // Limp-home active
  input wire mon_en_o,     // Effective monitor enable
  input wire bus_pll_o,    // Bus clock from PLL
  input wire mod_sel_o,    // Module clock select
  input wire mod_bkp_o,    // Module clocks on backup
  input wire cm_rst_o      // Monitor reset pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Sequences
  // ****************************************
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Supply loss passes two sync flops before it may force limp off
  sequence s_supply_gone;
    !pll_supply_i [*6];
  endsequence
  sequence s_stop_seen;
    $past(stop_req_i) || $past(stop_req_i, 2) || $past(stop_req_i, 3);
  endsequence

  a_ack_answer: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_cm_cause: assert property (
    cm_rst_o |-> $past(stop_req_i) || $past(stop_req_i, 2))
    else $error("monitor reset without stop request");
  a_cm_keeps_run: assert property (
    cm_rst_o |-> !stopped_o ##1 !stopped_o [*3])
    else $error("stop entered despite monitor failure");
  a_limp_monitor: assert property (limp_o |-> mon_en_o)
    else $error("monitor off during limp-home");
  a_limp_clocks: assert property (
    limp_o |-> mod_bkp_o && bus_pll_o && !mod_sel_o)
    else $error("clock selects not forced in limp-home");
  a_stop_entry: assert property ($rose(stopped_o) |-> s_stop_seen)
    else $error("stop entered without stop request");
  a_no_supply: assert property (s_supply_gone |-> !limp_o)
    else $error("limp-home active without PLL supply");
endmodule

// ### testbench.sv
// Self-checking bench for the stop exit and limp-home sequencer
`timescale 1ns/1ps
`include "selh_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench;
  localparam int DLY = 2 * `SELH_CNT_MID;  // Ticks come every 2nd cycle
  logic        clk_i, rst_i, cyc, stb, wen, stop_req, supply, ext_on;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rd;
  logic [5:0]  wake;  // Low irq, low nmi, key J, key H, CAN, low reset
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, ext_tick, bkp_tick, mon_ok, stopped_o, osc_run_o;
  wire         limp_o, bus_pll_o, mod_sel_o, cm_rst_o, lh_irq_o;
  wire         mon_en_o, pll_on_o, mod_bkp_o;
  int          mismatches, n_compared, n, n_cm, seed, regm[3];

  selh_osc_model osc (.clk_i(clk_i), .ext_on_i(ext_on),
    .ext_tick_o(ext_tick), .bkp_tick_o(bkp_tick), .mon_ok_o(mon_ok));
  selh_sequencer dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(wen), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pll_supply_i(supply),
    .ext_tick_i(ext_tick), .bkp_tick_i(bkp_tick), .mon_ok_i(mon_ok),
    .stop_req_i(stop_req), .ext_rst_n_i(~wake[5]), .irq_n_i(~wake[0]),
    .nmi_n_i(~wake[1]), .kwu_j_i(wake[2]), .kwu_h_i(wake[3]),
    .can_wu_i(wake[4]), .stopped_o(stopped_o), .osc_run_o(osc_run_o),
    .limp_o(limp_o), .mon_en_o(mon_en_o), .bus_pll_o(bus_pll_o),
    .mod_sel_o(mod_sel_o), .pll_on_o(pll_on_o), .mod_bkp_o(mod_bkp_o),
    .cm_rst_o(cm_rst_o), .lh_irq_o(lh_irq_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Count monitor reset pulses seen
  always @(posedge clk_i) if (cm_rst_o === 1'b1) n_cm++;

  // ****************************************
  // Bus and sequence tasks
  // ****************************************
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    wen <= w;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);  // Watchdog bounds it
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Control and slow writes update the model; other writes leave it alone
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
    if (a == `SELH_ADR_CTRL) regm[0] = d & 32'h1ff;
    if (a == `SELH_ADR_SLOW) regm[2] = d & 32'h3f;
  endtask
  task automatic rchk(input logic [3:0] a, input string nm);
    wb(a, 1'b0, 32'h0);
    `CHK(nm, (a[3:2] < 3) ? regm[a[3:2]] : 0, rd)  // Register model
  endtask
  task automatic clr_flag();
    wb(`SELH_ADR_STAT, 1'b1, 32'h2);
    regm[1] = regm[1] & 32'h5;
  endtask
  task automatic stop_pulse();
    stop_req <= 1'b1;
    @(posedge clk_i);
    stop_req <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wake_on(input int s);
    wake[s] <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake[s] <= 1'b0;
  endtask
  // Waits on stopped (w=0) or limp (w=1) under a bounded count
  task automatic wait_for(input int w, input logic v, input int lim);
    n = 0;
    while ((w ? limp_o : stopped_o) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 50000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {cyc, stb, wen, stop_req, wake, adr, wdat} = '0;
    {supply, ext_on, rst_i, sel} = {3'b111, 4'hf};
    seed = 32'h53d452a0;
    regm = '{32'h102, 0, 0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(0, 1'b0, DLY + 100);
    rchk(`SELH_ADR_CTRL, "ctrl_reset");
    rchk(`SELH_ADR_STAT, "stat_reset");
    for (int i = 0; i < 4; i++) begin
      wr(`SELH_ADR_CTRL, $random(seed));
      rchk(`SELH_ADR_CTRL, "ctrl_rw");
      wr(`SELH_ADR_SLOW, $random(seed));
      rchk(`SELH_ADR_SLOW, "slow_rw");
    end
    wr(4'hc, 32'hffffffff);
    rchk(4'hc, "unmapped");
    wr(`SELH_ADR_SLOW, 32'h0);
    done("registers");
    // Monitor on, limp-home off: the stop becomes a monitor reset
    wr(`SELH_ADR_CTRL, 32'h003);
    stop_pulse();
    `CHK("cm_pulses", 1, n_cm)
    `CHK("cm_run", 1'b0, stopped_o)
    done("monitor_fail");
    // Every wake source ends a stop without delay
    wr(`SELH_ADR_CTRL, 32'h001);
    for (int s = 0; s < 6; s++) begin
      stop_pulse();
      `CHK("stop_in", 1'b1, stopped_o)
      wake_on(s);
      wait_for(0, 1'b0, 12);
      `CHK("fast_exit", 1'b1, n < 12)
    end
    done("wake_sources");
    // Delay bit inserts the full count before release
    wr(`SELH_ADR_CTRL, 32'h009);
    stop_pulse();
    wake_on(2);
    wait_for(0, 1'b0, DLY + 100);
    `CHK("delay", 1'b1, n > DLY - 80 && n < DLY + 60)
    `CHK("no_limp", 1'b0, limp_o)
    done("delayed_exit");
    // Dead crystal: delayed exit ends in limp-home with flags set
    ext_on <= 1'b0;
    wr(`SELH_ADR_CTRL, 32'h058);  // PLL bus select kept clear
    stop_pulse();
    wake_on(3);
    wait_for(0, 1'b0, DLY + 100);
    `CHK("limp_delay", 1'b1, n > DLY - 80)
    `CHK("limp_in", 1'b1, limp_o)
    regm[1] = 3;
    rchk(`SELH_ADR_STAT, "stat_limp");
    `CHK("irq_limp", 1'b1, lh_irq_o)
    clr_flag();
    rchk(`SELH_ADR_STAT, "stat_clr");
    `CHK("irq_clr", 1'b0, lh_irq_o)
    ext_on <= 1'b1;
    wait_for(1, 1'b0, 2 * DLY + 200);
    `CHK("recover", 1'b1, n > DLY - 300 && n < 2 * DLY + 200)
    regm[1] = 2;
    rchk(`SELH_ADR_STAT, "stat_back");
    `CHK("irq_back", 1'b1, lh_irq_o)
    `CHK("restore", 2'b01, {bus_pll_o, mod_sel_o})
    clr_flag();
    done("limp_recovery");
    // Pseudo-stop keeps the crystal, passes limp-home, resumes external
    wr(`SELH_ADR_CTRL, 32'h098);
    stop_pulse();
    `CHK("osc_kept", 1'b1, osc_run_o)
    wake_on(4);
    wait_for(0, 1'b0, DLY + 100);
    `CHK("pstop_delay", 1'b1, n > DLY - 80)
    `CHK("pstop_ext", 1'b0, limp_o)
    regm[1] = 2;
    rchk(`SELH_ADR_STAT, "stat_pstop");
    clr_flag();
    done("pseudo_stop");
    // Fast recovery with dead crystal, then the PLL supply goes away
    ext_on <= 1'b0;
    wr(`SELH_ADR_CTRL, 32'h000);
    stop_pulse();
    wake_on(0);
    wait_for(0, 1'b0, 12);
    repeat (2) @(posedge clk_i);
    `CHK("fast_limp", 1'b1, n < 12 && limp_o)
    `CHK("limp_mon", 3'b111, {mon_en_o, pll_on_o, mod_bkp_o})
    supply <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK("unpowered", 1'b0, limp_o)
    `CHK("pll_off", 1'b0, pll_on_o)
    done("fast_and_supply");
    tally_and_finish();
  end
endmodule

bind selh_sequencer selh_sequencer_assertions chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pll_supply_i(pll_supply_i),
  .stop_req_i(stop_req_i), .stopped_o(stopped_o), .limp_o(limp_o),
  .mon_en_o(mon_en_o), .bus_pll_o(bus_pll_o), .mod_sel_o(mod_sel_o),
  .mod_bkp_o(mod_bkp_o), .cm_rst_o(cm_rst_o));
